// *** src/tc_consts.svh ***
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH

// Register byte offsets
`define TC_REG_CTRL      8'h00
`define TC_REG_RANGE     8'h04
`define TC_REG_STATUS    8'h08
`define TC_REG_INT_PEND  8'h0c
`define TC_REG_INT_MASK  8'h10
`define TC_REG_DATA_BASE 8'h20
`define TC_DATA_SPAN     8'h10

// Control fields
`define TC_CTRL_SCALE_F  0
`define TC_CTRL_BO_LSB   1
`define TC_CTRL_CH_LSB   3
`define TC_CTRL_RES16    5
`define TC_CTRL_COMMIT   7
`define TC_CTRL_RESET    8'h18

// Module status byte bits
`define TC_ST_SELFTEST   0
`define TC_ST_NO_SUPPLY  1
`define TC_ST_INVALID    2

// Range codes: 0..8 thermocouple J,E,K,R,S,T,B,N,C
`define TC_RNG_LAST_TC   4'h8
`define TC_RNG_UNI39     4'h9
`define TC_RNG_UNI156    4'hc
`define TC_RNG_UNI1250   4'he

// Celsius limits in tenths; Fahrenheit ones derive from them
`define TC_LIM_J_LO 16'hf894
`define TC_LIM_J_HI 16'h1db0
`define TC_LIM_E_LO 16'hf7cc
`define TC_LIM_E_HI 16'h2710
`define TC_LIM_K_LO 16'hfa24
`define TC_LIM_K_HI 16'h3598
`define TC_LIM_R_LO 16'h028a
`define TC_LIM_R_HI 16'h4510
`define TC_LIM_T_LO 16'hf704
`define TC_LIM_T_HI 16'h0fa0
`define TC_LIM_B_LO 16'h14aa
`define TC_LIM_B_HI 16'h4718
`define TC_LIM_N_LO 16'hfd44
`define TC_LIM_N_HI 16'h32c8
`define TC_LIM_C_HI 16'h5aa0
`define TC_F_MUL     24'sh000009
`define TC_F_DIV     24'sh000005
`define TC_F_OFS     24'sh000140
`define TC_BIP_LO    24'shff8000
`define TC_BIP_HI    24'sh007fff
`define TC_UNI_HI    24'sh00ffff

// Bus answer: waitrequest falls this many edges after the request
`define TC_BUS_WAIT  2'h2

`endif

// *** src/tc_pkg.sv ***
package tc_pkg;

  typedef enum logic [1:0] {
    TC_BO_OFF  = 2'h0,
    TC_BO_LOW  = 2'h1,
    TC_BO_HIGH = 2'h2
  } tc_bo_mode_t;

  typedef struct packed {
    logic        commit;
    logic        res16;
    logic [1:0]  chan_last;
    tc_bo_mode_t bo_mode;
    logic        scale_f;
  } tc_cfg_t;

  typedef struct packed {
    logic signed [19:0] value;
    logic               open_in;
  } tc_sample_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tc_avl_req_t;

  typedef enum logic [2:0] {
    TC_SC_REQ   = 3'b001,
    TC_SC_WAIT  = 3'b010,
    TC_SC_STORE = 3'b100
  } tc_scan_st_t;

endpackage

// *** src/tc_status_top.sv ***
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_status_top #(
  parameter int NCH = 4
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire tc_pkg::tc_avl_req_t avs_req_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               smp_valid_i,
  input  wire tc_pkg::tc_sample_t smp_i,
  output logic                    scan_req_o,
  output logic      [1:0]         scan_chan_o,
  output logic      [3:0]         scan_range_o,
  input  wire logic               self_test_fail_i,
  input  wire logic               supply_ok_i,
  output logic      [23:0]        status_o,
  output logic                    irq_o
);
  import tc_pkg::*;

  logic        rst_meta;
  logic        rst_n;
  tc_cfg_t     cfg;
  logic [15:0] range_cfg;
  logic        invalid;
  logic [1:0]  pin_sync;
  logic [7:0]  oor;
  logic [7:0]  burn;
  logic [23:0] status_prev;
  logic [23:0] int_pend;
  logic [23:0] int_mask;
  logic [1:0]  bus_cnt;
  logic        bus_req;
  logic        bus_done;
  logic        wr_ctrl;
  logic        wr_range;
  logic        rd_pend;
  logic [31:0] be_mask;
  logic [15:0] mem_rdata;
  logic [1:0]  chan;
  logic [3:0]  rng;
  tc_scan_st_t scan_st;
  tc_sample_t  smp_q;
  logic        fmt_we;
  logic [15:0] fmt_word;
  logic        fmt_oor;
  logic        fmt_burn;
  logic [23:0] status_now;
  logic [23:0] status_ev;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Self-test and supply sense come from pins
  tc_sync #(
    .W (2)
  ) u_pin_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .d_i     ({supply_ok_i, self_test_fail_i}),
    .q_o     (pin_sync)
  );

  // Bus slave: request, two wait edges, then waitrequest low for one
  assign bus_req  = avs_req_i.read | avs_req_i.write;
  assign bus_done = bus_req && (bus_cnt == `TC_BUS_WAIT);
  assign wr_ctrl  = bus_done && avs_req_i.write &&
                    (avs_req_i.address == `TC_REG_CTRL);
  assign wr_range = bus_done && avs_req_i.write &&
                    (avs_req_i.address == `TC_REG_RANGE);
  assign rd_pend  = bus_done && avs_req_i.read &&
                    (avs_req_i.address == `TC_REG_INT_PEND);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      be_mask[b*8 +: 8] = {8{avs_req_i.byteenable[b]}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_cnt           <= 2'h0;
      avs_waitrequest_o <= 1'b1;
    end else if (!bus_req || bus_done) begin
      bus_cnt           <= 2'h0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_cnt           <= bus_cnt + 2'h1;
      avs_waitrequest_o <= !(bus_cnt == `TC_BUS_WAIT - 2'h1);
    end
  end

  // Read mux captured on the same edge that waitrequest drops
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_req_i.read && bus_cnt == `TC_BUS_WAIT - 2'h1) begin
      if (avs_req_i.address >= `TC_REG_DATA_BASE &&
          avs_req_i.address <  `TC_REG_DATA_BASE + `TC_DATA_SPAN &&
          avs_req_i.address[1:0] == 2'h0) begin
        avs_readdata_o <= {16'h0, mem_rdata};
      end else begin
        case (avs_req_i.address)
          `TC_REG_CTRL:     avs_readdata_o <= {25'h0, cfg};
          `TC_REG_RANGE:    avs_readdata_o <= {16'h0, range_cfg};
          `TC_REG_STATUS:   avs_readdata_o <= {8'h0, status_o};
          `TC_REG_INT_PEND: avs_readdata_o <= {8'h0, int_pend};
          `TC_REG_INT_MASK: avs_readdata_o <= {8'h0, int_mask};
          default:          avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Configuration writes; commit is a pulse bit that reads back zero
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 7'(`TC_CTRL_RESET);
    end else if (wr_ctrl) begin
      cfg <= (cfg & ~be_mask[6:0]) |
             (avs_req_i.writedata[6:0] & be_mask[6:0]);
      cfg.commit <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      range_cfg <= 16'h0;
    end else if (wr_range) begin
      range_cfg <= (range_cfg & ~be_mask[15:0]) |
                   (avs_req_i.writedata[15:0] & be_mask[15:0]);
    end
  end

  // Unconfigured or changed ranges stay invalid until a commit write
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      invalid <= 1'b1;
    end else if (wr_range) begin
      invalid <= 1'b1;
    end else if (wr_ctrl && avs_req_i.writedata[`TC_CTRL_COMMIT] &&
                 avs_req_i.byteenable[0]) begin
      invalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= 24'h0;
    end else if (bus_done && avs_req_i.write &&
                 avs_req_i.address == `TC_REG_INT_MASK) begin
      int_mask <= (int_mask & ~be_mask[23:0]) |
                  (avs_req_i.writedata[23:0] & be_mask[23:0]);
    end
  end

  // Scan walks enabled channels only; fewer channels, faster refresh
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_st      <= TC_SC_REQ;
      chan         <= 2'h0;
      scan_req_o   <= 1'b0;
      scan_chan_o  <= 2'h0;
      scan_range_o <= 4'h0;
      smp_q        <= '0;
    end else begin
      scan_req_o <= 1'b0;
      case (scan_st)
        TC_SC_REQ: begin
          scan_req_o   <= 1'b1;
          scan_chan_o  <= chan;
          scan_range_o <= range_cfg[chan*4 +: 4];
          scan_st      <= TC_SC_WAIT;
        end
        TC_SC_WAIT: begin
          if (smp_valid_i) begin
            smp_q   <= smp_i;
            scan_st <= TC_SC_STORE;
          end
        end
        TC_SC_STORE: begin
          chan    <= (chan >= cfg.chan_last) ? 2'h0 : chan + 2'h1;
          scan_st <= TC_SC_REQ;
        end
        default: scan_st <= TC_SC_REQ;
      endcase
    end
  end

  assign rng    = scan_range_o;
  assign fmt_we = (scan_st == TC_SC_STORE);

  // Result formatting: clamp to range limits, flag, open override
  always_comb begin
    logic signed [23:0] lo;
    logic signed [23:0] hi;
    logic signed [23:0] v;
    logic [15:0]        lo16;
    logic [15:0]        hi16;
    logic               uni;
    lo   = 24'sh0;
    hi   = 24'sh0;
    v    = 24'sh0;
    lo16 = 16'h0;
    hi16 = 16'h0;
    uni  = (rng == `TC_RNG_UNI39) || (rng == `TC_RNG_UNI156) ||
           (rng == `TC_RNG_UNI1250);
    case (rng)
      4'h0: begin lo16 = `TC_LIM_J_LO; hi16 = `TC_LIM_J_HI; end
      4'h1: begin lo16 = `TC_LIM_E_LO; hi16 = `TC_LIM_E_HI; end
      4'h2: begin lo16 = `TC_LIM_K_LO; hi16 = `TC_LIM_K_HI; end
      4'h3: begin lo16 = `TC_LIM_R_LO; hi16 = `TC_LIM_R_HI; end
      4'h4: begin lo16 = `TC_LIM_R_LO; hi16 = `TC_LIM_R_HI; end
      4'h5: begin lo16 = `TC_LIM_T_LO; hi16 = `TC_LIM_T_HI; end
      4'h6: begin lo16 = `TC_LIM_B_LO; hi16 = `TC_LIM_B_HI; end
      4'h7: begin lo16 = `TC_LIM_N_LO; hi16 = `TC_LIM_N_HI; end
      4'h8: begin lo16 = `TC_LIM_R_LO; hi16 = `TC_LIM_C_HI; end
      default: begin lo16 = 16'h0; hi16 = 16'h0; end
    endcase
    v = 24'(smp_q.value);
    if (rng <= `TC_RNG_LAST_TC) begin
      lo = 24'(signed'(lo16));
      hi = 24'(signed'(hi16));
      if (cfg.scale_f) begin
        // Tenths of F = tenths of C * 9 / 5 + 32.0
        lo = lo * `TC_F_MUL / `TC_F_DIV + `TC_F_OFS;
        hi = hi * `TC_F_MUL / `TC_F_DIV + `TC_F_OFS;
        v  = v  * `TC_F_MUL / `TC_F_DIV + `TC_F_OFS;
      end
    end else if (uni) begin
      lo = 24'sh0;
      hi = `TC_UNI_HI;
    end else begin
      lo = `TC_BIP_LO;
      hi = `TC_BIP_HI;
    end
    fmt_oor = 1'b0;
    if (v < lo) begin
      v       = lo;
      fmt_oor = 1'b1;
    end else if (v > hi) begin
      v       = hi;
      fmt_oor = 1'b1;
    end
    // Fifteen-bit unipolar halves the count: 0..32767
    if (uni && !cfg.res16) begin
      v  = v >>> 1;
      lo = lo >>> 1;
      hi = hi >>> 1;
    end
    fmt_burn = smp_q.open_in && (cfg.bo_mode != TC_BO_OFF);
    if (fmt_burn) begin
      fmt_word = (cfg.bo_mode == TC_BO_HIGH) ? hi[15:0] : lo[15:0];
      fmt_oor  = 1'b0;
    end else begin
      fmt_word = v[15:0];
    end
  end

  tc_word_mem #(
    .DEPTH (NCH),
    .W     (16)
  ) u_words (
    .clk_i   (clk_sys_i),
    .we_i    (fmt_we),
    .waddr_i (chan),
    .wdata_i (fmt_word),
    .raddr_i (avs_req_i.address[3:2]),
    .rdata_o (mem_rdata)
  );

  // Per-channel flags; disabled channels read clear
  for (genvar c = 0; c < 8; c++) begin : g_flag
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
        oor[c]  <= 1'b0;
        burn[c] <= 1'b0;
      end else if (c >= NCH || c > cfg.chan_last) begin
        oor[c]  <= 1'b0;
        burn[c] <= 1'b0;
      end else if (fmt_we && chan == 2'(c)) begin
        oor[c]  <= fmt_oor;
        burn[c] <= fmt_burn;
      end
    end
  end

  always_comb begin
    status_now = {burn, oor, 8'h0};
    status_now[`TC_ST_SELFTEST]  = pin_sync[0];
    status_now[`TC_ST_NO_SUPPLY] = !pin_sync[1];
    status_now[`TC_ST_INVALID]   = invalid;
  end

  assign status_ev = status_now & ~status_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      status_o    <= 24'h0;
      status_prev <= 24'h0;
    end else begin
      status_o    <= status_now;
      status_prev <= status_now;
    end
  end

  // Pending bits clear on read; a rising flag in that cycle still lands
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      int_pend <= 24'h0;
    end else begin
      int_pend <= (rd_pend ? 24'h0 : int_pend) | status_ev;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((rd_pend ? 24'h0 : int_pend) | status_ev) & int_mask);
    end
  end

endmodule

// *** src/tc_sync.sv ***
`timescale 1ns/10ps
module tc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// *** src/tc_word_mem.sv ***
`timescale 1ns/10ps
module tc_word_mem #(
  parameter int DEPTH = 4,
  parameter int W     = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read so the bus mux sees a settled word
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** tb/tb_thermocouple_input_result_and_status.sv ***
`timescale 1ns/10ps
`include "tc_consts.svh"
module tb_thermocouple_input_result_and_status;
  import tc_pkg::*;
  logic               clk_sys_i, rst_n_i, avs_waitrequest_o, smp_valid_i;
  logic               scan_req_o, self_test_fail_i, supply_ok_i, irq_o;
  logic [1:0]         scan_chan_o;
  logic [3:0]         scan_range_o, open_in;
  logic [23:0]        status_o;
  logic [31:0]        avs_readdata_o, q;
  logic signed [19:0] val [4];
  tc_avl_req_t        avs_req_i;
  tc_sample_t         smp_i;
  int                 cnt, error_cnt, comparisons;
  tc_status_top #(.NCH(4)) u_dut (.clk_sys_i, .rst_n_i, .avs_req_i,
    .avs_readdata_o, .avs_waitrequest_o, .smp_valid_i, .smp_i, .scan_req_o,
    .scan_chan_o, .scan_range_o, .self_test_fail_i, .supply_ok_i,
    .status_o, .irq_o);
  tc_conv_model u_conv (.clk_i(clk_sys_i), .rst_n_i, .scan_req_i(scan_req_o),
    .chan_i(scan_chan_o), .val_i(val), .open_i(open_in),
    .smp_valid_o(smp_valid_i), .smp_o(smp_i), .cnt_o(cnt));
  task automatic cmp(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is seen low, then idles one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_req_i <= '{!w, w, a, 4'hf, d};
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0 && n < 40) begin
      n++;
      @(posedge clk_sys_i);
    end
    cmp("bus answer", 32'h0, 32'(n == 40));
    q = avs_readdata_o;
    avs_req_i <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, string nm);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, q & m);
  endtask
  task automatic scan(input int n);
    int t;
    t = cnt + n;
    for (int k = 0; k < 400 && cnt < t; k++) @(posedge clk_sys_i);
    cmp("samples", 32'(t), 32'(cnt));
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic t_reset;
    rd(`TC_REG_CTRL, 32'hff, 32'h18, "ctrl reset");
    rd(`TC_REG_STATUS, 32'hff0000ff, 32'h04, "status reset");
    rd(`TC_REG_INT_MASK, 32'hffffff, 32'h0, "mask reset");
    rd(8'h14, 32'hffffffff, 32'h0, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_celsius;
    bus(1'b1, `TC_REG_RANGE, 32'h0);
    cmp("irq masked", 32'h0, 32'(irq_o));
    bus(1'b1, `TC_REG_CTRL, 32'h98);
    scan(5);
    cmp("invalid", 32'h0, 32'(status_o[2]));
    rd(8'h20, 32'hffff, 32'h04d2, "word1");
    rd(8'h24, 32'hffff, 32'h1db0, "word2 clamp");
    rd(8'h28, 32'hffff, 32'hf894, "word3");
    cmp("flags", 32'h0002, 32'(status_o[23:8]));
    bus(1'b1, `TC_REG_INT_MASK, 32'h200);
    @(posedge clk_sys_i);
    cmp("irq raised", 32'h1, 32'(irq_o));
    rd(`TC_REG_INT_PEND, 32'h200, 32'h200, "pending");
    @(posedge clk_sys_i);
    cmp("irq cleared", 32'h0, 32'(irq_o));
    $display("t_celsius done");
  endtask
  task automatic t_open;
    logic [15:0] ew [3];
    ew = '{16'h022b, 16'hf894, 16'h1db0};
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `TC_REG_CTRL, 32'h98 | 32'(m << 1));
      scan(5);
      rd(8'h2c, 32'hffff, 32'(ew[m]), "open word");
      cmp("open flag", 32'(m != 0), 32'(status_o[19]));
    end
    bus(1'b1, `TC_REG_CTRL, 32'h99);
    scan(5);
    rd(8'h20, 32'hffff, 32'h09ed, "word1 F");
    rd(8'h24, 32'hffff, 32'h36b0, "word2 F clamp");
    $display("t_open done");
  endtask
  task automatic t_volt;
    val[0] <= -20'sd32768;
    val[1] <= 20'sd65535;
    bus(1'b1, `TC_REG_RANGE, 32'h9a);
    @(posedge clk_sys_i);
    cmp("invalid after range", 32'h1, 32'(status_o[2]));
    bus(1'b1, `TC_REG_CTRL, 32'h98);
    scan(5);
    rd(8'h20, 32'hffff, 32'h8000, "bipolar min");
    rd(8'h24, 32'hffff, 32'h7fff, "unipolar 15");
    bus(1'b1, `TC_REG_CTRL, 32'hb8);
    scan(5);
    rd(8'h24, 32'hffff, 32'hffff, "unipolar 16");
    $display("t_volt done");
  endtask
  task automatic t_chans;
    int bad;
    int n0;
    bus(1'b1, `TC_REG_CTRL, 32'h80);
    scan(2);
    bad = 0;
    n0 = 0;
    repeat (80) begin
      @(posedge clk_sys_i);
      if (scan_req_o === 1'b1 && scan_chan_o !== 2'h0) bad++;
      if (scan_req_o === 1'b1 && scan_chan_o === 2'h0) n0++;
    end
    cmp("other channel scanned", 32'h0, 32'(bad));
    cmp("channel 1 rate", 32'h1, 32'(n0 >= 8));
    cmp("disabled flags", 32'h0, 32'(status_o[23:9]));
    cmp("scan range", 32'ha, 32'(scan_range_o));
    bus(1'b1, `TC_REG_CTRL, 32'h98);
    $display("t_chans done");
  endtask
  task automatic t_pins;
    self_test_fail_i <= 1'b1;
    supply_ok_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    cmp("pin flags", 32'h3, 32'(status_o[1:0]));
    rd(`TC_REG_STATUS, 32'h3, 32'h3, "status reg");
    self_test_fail_i <= 1'b0;
    supply_ok_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    cmp("pin flags clear", 32'h0, 32'(status_o[1:0]));
    $display("t_pins done");
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Whole run is under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("Error watchdog expected end seen hang");
    summarize;
  end
  initial begin
    rst_n_i = 1'b0;
    avs_req_i = '0;
    self_test_fail_i = 1'b0;
    supply_ok_i = 1'b1;
    val = '{20'sd1234, 20'sd8000, -20'sd1900, 20'sd555};
    open_in = 4'h8;
    error_cnt = 0;
    comparisons = 0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset;
    t_celsius;
    t_open;
    t_volt;
    t_chans;
    t_pins;
    summarize;
  end
endmodule

// *** tb/tc_conv_model.sv ***
`timescale 1ns/10ps
module tc_conv_model (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               scan_req_i,
  input  wire logic [1:0]         chan_i,
  input  wire logic signed [19:0] val_i [4],
  input  wire logic [3:0]         open_i,
  output logic                    smp_valid_o,
  output tc_pkg::tc_sample_t      smp_o,
  output int                      cnt_o
);
  logic [1:0] ch;
  logic [3:0] wait_cnt;
  // Answers alternate prompt and slow; off the strobe the data toggles
  // so a design sampling outside it reads garbage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch          <= 2'h0;
      wait_cnt    <= 4'h0;
      smp_valid_o <= 1'b0;
      smp_o       <= '0;
      cnt_o       <= 0;
    end else begin
      smp_valid_o <= 1'b0;
      smp_o       <= ~smp_o;
      if (scan_req_i) begin
        ch       <= chan_i;
        wait_cnt <= cnt_o[0] ? 4'h2 : 4'h7;
      end else if (wait_cnt > 4'h1) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (wait_cnt == 4'h1) begin
        wait_cnt    <= 4'h0;
        smp_valid_o <= 1'b1;
        smp_o       <= '{value: val_i[ch], open_in: open_i[ch]};
        cnt_o       <= cnt_o + 1;
      end
    end
  end
endmodule

// *** tb/tc_status_assertions.sv ***
`timescale 1ns/10ps
`include "tc_consts.svh"
module tc_status_assertions #(
  parameter int NCH = 4
) (
  input wire logic                clk_sys_i,
  input wire logic                rst_n_i,
  input wire tc_pkg::tc_avl_req_t avs_req_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic                smp_valid_i,
  input wire tc_pkg::tc_sample_t  smp_i,
  input wire logic                scan_req_o,
  input wire logic [1:0]          scan_chan_o,
  input wire logic [3:0]          scan_range_o,
  input wire logic                self_test_fail_i,
  input wire logic                supply_ok_i,
  input wire logic [23:0]         status_o,
  input wire logic                irq_o
);
  logic wr_seen;
  logic wr_ok;
  assign wr_ok = avs_req_i.write && !avs_waitrequest_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Mask resets to zero, so no interrupt may show before any write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) wr_seen <= 1'b0;
    else if (avs_req_i.write) wr_seen <= 1'b1;
  end
  chk_bus_answer: assert property (
    $rose(avs_req_i.read || avs_req_i.write)
    |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o)
    else $error("bus answer not on the third edge");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_module_spare: assert property (status_o[7:3] == 5'h0)
    else $error("spare module status bits set");
  chk_chan_spare: assert property (
    (status_o[15:8] >> NCH) == 8'h0 && (status_o[23:16] >> NCH) == 8'h0)
    else $error("flag of a missing channel set");
  chk_selftest_flag: assert property (
    $stable(self_test_fail_i) [*8] |-> status_o[0] == self_test_fail_i)
    else $error("self-test flag does not follow its pin");
  chk_supply_flag: assert property (
    $stable(supply_ok_i) [*8] |-> status_o[1] == !supply_ok_i)
    else $error("supply flag does not follow its pin");
  chk_irq_quiet: assert property (!wr_seen |-> !irq_o)
    else $error("interrupt while mask still at reset");
  chk_scan_pulse: assert property (scan_req_o |=> !scan_req_o)
    else $error("scan request longer than one cycle");
  chk_scan_next: assert property (smp_valid_i |-> ##3 scan_req_o)
    else $error("next scan not three edges after sample");
  chk_range_invalid: assert property (
    wr_ok && avs_req_i.address == `TC_REG_RANGE
    |=> ##[0:2] status_o[`TC_ST_INVALID])
    else $error("range write did not flag invalid data");
  chk_commit_valid: assert property (
    wr_ok && avs_req_i.address == `TC_REG_CTRL && avs_req_i.byteenable[0]
    && avs_req_i.writedata[`TC_CTRL_COMMIT]
    |=> ##[0:2] !status_o[`TC_ST_INVALID])
    else $error("commit did not clear invalid data");
endmodule
bind tc_status_top tc_status_assertions #(.NCH(NCH)) u_chk (
  .clk_sys_i, .rst_n_i, .avs_req_i, .avs_readdata_o, .avs_waitrequest_o,
  .smp_valid_i, .smp_i, .scan_req_o, .scan_chan_o, .scan_range_o,
  .self_test_fail_i, .supply_ok_i, .status_o, .irq_o);
